/* inc/fspc_pkg.sv */
// constants, carriers and decode helpers for the flash security/protection block
package fspc_pkg;

  // register indices within the flash register page
  localparam logic [2:0] FSPC_IDX_OPT  = 3'h1;
  localparam logic [2:0] FSPC_IDX_CFG  = 3'h3;
  localparam logic [2:0] FSPC_IDX_PROT = 3'h4;
  localparam logic [2:0] FSPC_IDX_STAT = 3'h5;

  // options register fields
  localparam int         FSPC_OPT_BACKDOOR_KEY_ENABLE_BIT = 7;
  localparam int         FSPC_OPT_NORED_BIT = 6;
  localparam int         FSPC_OPT_SEC_LSB   = 0;
  localparam logic [7:0] FSPC_OPT_MASK      = 8'hC3;
  localparam logic [1:0] FSPC_SEC_OPEN      = 2'h2;

  // configuration register fields
  localparam int         FSPC_CFG_KEY_ACCESS_ENABLE_BIT = 5;
  localparam logic [7:0] FSPC_CFG_MASK       = 8'h20;
  localparam logic [7:0] FSPC_CFG_RST        = 8'h00;

  // protection register fields
  localparam int         FSPC_PROT_DIS_BIT = 0;
  localparam int         FSPC_PAGE_BITS    = 9;

  // status register fields
  localparam int         FSPC_STAT_VIOL_BIT = 5;
  localparam logic [7:0] FSPC_STAT_RST      = 8'h00;

  // backdoor key window
  localparam logic [15:0] FSPC_KEY_BASE  = 16'hFFB0;
  localparam int          FSPC_KEY_BYTES = 8;
  localparam logic [3:0]  FSPC_KEY_FULL  = 4'h8;

  // register port request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       dbg;
    logic [2:0] idx;
    logic [7:0] wdata;
  } fspc_reg_req_s;

  // flash array write request
  typedef struct packed {
    logic        wr;
    logic        dbg;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } fspc_mem_wr_s;

  // only one code of the two-bit field leaves the part open
  function automatic logic fspc_sec_open(input logic [1:0] field);
    return field == FSPC_SEC_OPEN;
  endfunction

  // address falls in the eight-byte key window
  function automatic logic fspc_in_key(input logic [15:0] addr);
    return addr[15:3] == FSPC_KEY_BASE[15:3];
  endfunction

endpackage

/* core/fspc_prot_chk.sv */
// protected-region address check and grow-only write filter
`timescale 1ns/1ns
module fspc_prot_chk
  import fspc_pkg::*;
(
  input  wire logic [7:0]  prot_i,    // current protection register
  input  wire logic [15:0] addr_i,    // address of a program/erase
  input  wire logic [7:0]  new_i,     // value offered by a write
  output logic             hit_o,     // address lies in protected end
  output logic             grow_ok_o  // write may be taken
);

  logic [15:0] open_end;
  logic [15:0] new_end;
  logic        prot_off;

  // select field names the last unprotected address, its low nine bits all ones
  assign prot_off = prot_i[FSPC_PROT_DIS_BIT];
  assign open_end = {prot_i[7:1], {FSPC_PAGE_BITS{1'b1}}};
  assign new_end  = {new_i[7:1], {FSPC_PAGE_BITS{1'b1}}};

  // high end above the select point
  assign hit_o = !prot_off && (addr_i > open_end);

  // only a lower end point is a larger region
  assign grow_ok_o = prot_off ||
                     (!new_i[FSPC_PROT_DIS_BIT] && (new_end < open_end));

endmodule // fspc_prot_chk

/* core/fspc_key_cmp.sv */
// capture of the eight comparison bytes and match against the stored key
`timescale 1ns/1ns
module fspc_key_cmp
  import fspc_pkg::*;
(
  input  wire logic        clk_i,     // bus clock
  input  wire logic        rst_b_i,   // synchronous reset, active low
  input  wire logic        clear_i,   // start a fresh entry
  input  wire logic        wr_i,      // key byte write
  input  wire logic [2:0]  idx_i,     // byte position in window
  input  wire logic [7:0]  data_i,    // key byte
  input  wire logic [63:0] key_i,     // stored key, byte 0 lowest
  output logic             match_o    // full, ordered, equal entry
);

  logic [7:0] key_buf [FSPC_KEY_BYTES];
  logic [3:0] count;
  logic       order_ok;
  logic       in_order;
  logic       equal;

  // bytes must arrive strictly ascending from the first
  assign in_order = ({1'b0, idx_i} == count);

  // buffer and ordering tracker
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i || clear_i)
    begin
      count    <= 4'h0;
      order_ok <= 1'b1;
    end
    else if (wr_i)
    begin
      key_buf[idx_i] <= data_i;
      order_ok       <= order_ok && in_order && (count != FSPC_KEY_FULL);
      if (count != FSPC_KEY_FULL)
        count <= count + 4'h1;
    end
  end

  // byte-wise compare
  always_comb
  begin
    equal = 1'b1;
    for (int i = 0; i < FSPC_KEY_BYTES; i++)
      if (key_buf[i] != key_i[8*i +: 8])
        equal = 1'b0;
  end

  assign match_o = order_ok && (count == FSPC_KEY_FULL) && equal;

endmodule // fspc_key_cmp

/* core/fspc_ctrl.sv */
// flash options, security key gating and block protection control
`timescale 1ns/1ns
module fspc_ctrl
  import fspc_pkg::*;
(
  input  wire logic          clk_i,                 // bus clock, 25 MHz
  input  wire logic          rst_b_i,               // synchronous reset, active low
  input  wire logic [7:0]    nv_options_copy_i,     // nonvolatile options byte
  input  wire logic [7:0]    nv_protection_copy_i,  // nonvolatile protection byte
  input  wire logic [63:0]   stored_backdoor_key_i, // stored key, byte 0 lowest
  input  wire fspc_reg_req_s reg_req_i,             // register port request
  output logic [7:0]         rd_data_o,             // register read data
  input  wire fspc_mem_wr_s  mem_wr_i,              // flash array write
  input  wire logic          mem_acc_req_i,         // memory content access
  input  wire logic          unsecure_src_i,        // access from unsecured source
  input  wire logic          blank_ok_i,            // blank check found all erased
  output logic               mem_acc_grant_o,       // memory access allowed
  output logic               cmd_start_o,           // flash command launched
  output logic [15:0]        cmd_addr_o,            // address of launched command
  output logic [7:0]         cmd_data_o,            // data of launched command
  output logic               secure_o,              // part is secured
  output logic               vector_redirect_en_o,  // vector redirection active
  output logic               backdoor_key_enable_o, // key mechanism enabled
  output logic               key_access_enable_o,   // key window in key mode
  output logic               protection_violation_flag_o // sticky violation
);

  // key entry sequencing
  typedef enum logic [1:0] {
    FSPC_KEY_IDLE    = 2'b00,
    FSPC_KEY_COLLECT = 2'b01,
    FSPC_KEY_CHECK   = 2'b10
  } fspc_key_e;

  fspc_key_e  key_state;
  fspc_key_e  next_key_state;

  logic [7:0] flash_options;
  logic [7:0] flash_config;
  logic [7:0] flash_protection;
  logic [7:0] flash_status;

  logic [1:0] security_state_field;
  logic       backdoor_key_enable;
  logic       vector_redirect_disable;
  logic       key_access_enable;
  logic       sec_open;

  logic       wr_cfg;
  logic       wr_prot;
  logic       wr_stat;
  logic       rd_hit;
  logic [7:0] rd_value;

  logic       in_key;
  logic       key_byte_wr;
  logic       cmd_req;
  logic       win_key_wr;
  logic       cmd_go;
  logic       rd_take;
  logic       open_evt;
  logic       prot_hit;
  logic       grow_ok;
  logic       key_match;
  logic       key_clear;
  logic       key_granted;
  logic       unlock_key;
  logic       viol_set;
  logic       viol_clr;
  logic       next_viol;

  // field views of the stored registers
  assign security_state_field    = flash_options[FSPC_OPT_SEC_LSB +: 2];
  assign backdoor_key_enable     = flash_options[FSPC_OPT_BACKDOOR_KEY_ENABLE_BIT];
  assign vector_redirect_disable = flash_options[FSPC_OPT_NORED_BIT];
  assign key_access_enable       = flash_config[FSPC_CFG_KEY_ACCESS_ENABLE_BIT];

  assign sec_open = fspc_sec_open(security_state_field);

  // register write decode
  // configuration and status take either source
  assign wr_cfg  = reg_req_i.wr && (reg_req_i.idx == FSPC_IDX_CFG);
  assign wr_prot = reg_req_i.wr && reg_req_i.dbg && (reg_req_i.idx == FSPC_IDX_PROT);
  assign wr_stat = reg_req_i.wr && (reg_req_i.idx == FSPC_IDX_STAT);

  // flash write steering
  assign in_key = fspc_in_key(mem_wr_i.addr);
  // key mode turns window writes into comparison bytes
  assign win_key_wr = mem_wr_i.wr && in_key && key_access_enable;
  // debug-sourced bytes are dropped outright
  // outside collection a byte is dropped so a stale entry cannot finish
  assign key_byte_wr = win_key_wr && !mem_wr_i.dbg && (key_state == FSPC_KEY_COLLECT);
  // otherwise a write is the start of a command
  assign cmd_req = mem_wr_i.wr && !win_key_wr;
  // a protected target is dropped here and flagged below
  assign cmd_go  = cmd_req && !prot_hit;

  // protection check and write filter
  // the filter judges every offered byte; only a debug write uses it
  fspc_prot_chk u_prot_chk (
    .prot_i    (flash_protection),
    .addr_i    (mem_wr_i.addr),
    .new_i     (reg_req_i.wdata),
    .hit_o     (prot_hit),
    .grow_ok_o (grow_ok)
  );

  // comparison byte capture
  fspc_key_cmp u_key_cmp (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .clear_i (key_clear),
    .wr_i    (key_byte_wr),
    .idx_i   (mem_wr_i.addr[2:0]),
    .data_i  (mem_wr_i.wdata),
    .key_i   (stored_backdoor_key_i),
    .match_o (key_match)
  );

  // key entry state machine
  always_comb
  begin
    next_key_state = key_state;
    key_clear      = 1'b0;
    case (key_state)
      FSPC_KEY_IDLE:
      begin
        if (key_access_enable)
        begin
          // a fresh entry resets the byte count and order flag of the last one
          key_clear      = 1'b1;
          next_key_state = FSPC_KEY_COLLECT;
        end
      end
      FSPC_KEY_COLLECT:
      begin
        // clearing key access closes the entry
        if (!key_access_enable)
          next_key_state = FSPC_KEY_CHECK;
      end
      FSPC_KEY_CHECK:
      begin
        // one cycle only, so an entry unlocks at most once
        next_key_state = FSPC_KEY_IDLE;
      end
      default:
      begin
        next_key_state = FSPC_KEY_IDLE;
      end
    endcase
  end

  // enable bit gates the backdoor unlock
  // bytes are still collected with it clear; only the unlock is withheld
  assign key_granted = backdoor_key_enable;
  // compare once the entry is closed
  assign unlock_key = (key_state == FSPC_KEY_CHECK) && key_granted && key_match;
  assign open_evt   = unlock_key || blank_ok_i;

  // violation flag, set wins over clear so no event is lost
  // protected command dropped and flagged
  assign viol_set  = cmd_req && prot_hit;
  assign viol_clr  = wr_stat && reg_req_i.wdata[FSPC_STAT_VIOL_BIT];
  assign next_viol = viol_set || (flash_status[FSPC_STAT_VIOL_BIT] && !viol_clr);

  // only a mapped read drives the data lines
  assign rd_take = reg_req_i.rd && rd_hit;

  // read selection
  // protection readable at any time
  always_comb
  begin
    rd_hit = 1'b1;
    case (reg_req_i.idx)
      FSPC_IDX_OPT:  rd_value = flash_options & FSPC_OPT_MASK;
      FSPC_IDX_CFG:  rd_value = flash_config & FSPC_CFG_MASK;
      FSPC_IDX_PROT: rd_value = flash_protection;
      FSPC_IDX_STAT: rd_value = flash_status;
      default:
      begin
        rd_value = 8'h00;
        rd_hit   = 1'b0;
      end
    endcase
  end

  // key sequencer state
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      key_state <= FSPC_KEY_IDLE;
    else
      key_state <= next_key_state;
  end

  // options register: read-only, security may only open up
  always_ff @(posedge clk_i)
  begin
    // nonvolatile copy taken on every reset
    if (!rst_b_i)
      flash_options <= nv_options_copy_i & FSPC_OPT_MASK;
    // key match or clean blank check opens the part
    // open lasts until the next reset reload
    else if (open_evt)
      flash_options[FSPC_OPT_SEC_LSB +: 2] <= FSPC_SEC_OPEN;
  end

  // configuration register
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      flash_config <= FSPC_CFG_RST;
    // only the key access bit is kept
    else if (wr_cfg)
      flash_config <= reg_req_i.wdata & FSPC_CFG_MASK;
  end

  // protection register
  always_ff @(posedge clk_i)
  begin
    // nonvolatile copy taken on every reset
    if (!rst_b_i)
      flash_protection <= nv_protection_copy_i;
    // shrinking writes leave it untouched
    // a shrink attempt is dropped whole, never clipped
    else if (wr_prot && grow_ok)
      flash_protection <= reg_req_i.wdata;
  end

  // status register, violation bit only
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      flash_status <= FSPC_STAT_RST;
    else
      flash_status[FSPC_STAT_VIOL_BIT] <= next_viol;
  end

  // command launch, dropped when it hits the protected end
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      cmd_start_o <= 1'b0;
      cmd_addr_o  <= 16'h0000;
      cmd_data_o  <= 8'h00;
    end
    else
    begin
      cmd_start_o <= cmd_go;
      // address and data hold between launches
      if (cmd_go)
      begin
        cmd_addr_o <= mem_wr_i.addr;
        cmd_data_o <= mem_wr_i.wdata;
      end
    end
  end

  // memory access gate, one cycle after the request
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      mem_acc_grant_o <= 1'b0;
    // secure part refuses unsecured sources
    // trusted sources still pass while secure
    else
      mem_acc_grant_o <= mem_acc_req_i && (sec_open || !unsecure_src_i);
  end

  // register read data, zero for unmapped or idle
  always_ff @(posedge clk_i)
  begin
    // idle zero lets the core merge several read sources
    if (!rst_b_i)
      rd_data_o <= 8'h00;
    else if (rd_take)
      rd_data_o <= rd_value;
    else
      rd_data_o <= 8'h00;
  end

  // security outputs, registered so they lag the fields by one edge
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      // fail safe: secure until the loaded code is seen
      secure_o              <= 1'b1;
      vector_redirect_en_o  <= 1'b0;
      backdoor_key_enable_o <= 1'b0;
    end
    else
    begin
      secure_o              <= !sec_open;
      vector_redirect_en_o  <= !vector_redirect_disable;
      backdoor_key_enable_o <= backdoor_key_enable;
    end
  end

  // mirrors of the configuration and status bits
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      key_access_enable_o         <= 1'b0;
      protection_violation_flag_o <= 1'b0;
    end
    else
    begin
      key_access_enable_o         <= key_access_enable;
      protection_violation_flag_o <= flash_status[FSPC_STAT_VIOL_BIT];
    end
  end

endmodule // fspc_ctrl

/* bench/fspc_ctrl_sva.sv */
// assertion checker for the flash security and protection control block
`timescale 1ns/1ns
module fspc_ctrl_sva
  import fspc_pkg::*;
(
  input wire logic          clk_i,                      // clock
  input wire logic          rst_b_i,                    // reset
  input wire fspc_reg_req_s reg_req_i,                  // reg request
  input wire logic [7:0]    rd_data_o,                  // read data
  input wire fspc_mem_wr_s  mem_wr_i,                   // flash write
  input wire logic          mem_acc_req_i,              // access req
  input wire logic          unsecure_src_i,             // source kind
  input wire logic          blank_ok_i,                 // blank pass
  input wire logic          mem_acc_grant_o,            // grant
  input wire logic          cmd_start_o,                // command
  input wire logic [15:0]   cmd_addr_o,                 // cmd address
  input wire logic [7:0]    cmd_data_o,                 // cmd data
  input wire logic          secure_o,                   // secured
  input wire logic          backdoor_key_enable_o,      // key enable
  input wire logic          key_access_enable_o,        // key mode
  input wire logic          protection_violation_flag_o // violation
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  // decoded request kinds
  wire clr_w = reg_req_i.wr && reg_req_i.idx == FSPC_IDX_STAT &&
               reg_req_i.wdata[FSPC_STAT_VIOL_BIT];
  wire win_w = mem_wr_i.wr && mem_wr_i.addr[15:3] == FSPC_KEY_BASE[15:3];

  // secure_o one cycle on reflects the state the grant was decided on
  sequence s_deny;
    mem_acc_req_i && unsecure_src_i ##1 secure_o;
  endsequence

  // key_access_enable_o one cycle on mirrors the mode the write was steered by
  sequence s_key_win;
    win_w ##1 key_access_enable_o;
  endsequence

  property p_rd_idle; !reg_req_i.rd |=> rd_data_o == 8'h00; endproperty
  property p_cmd_src;
    cmd_start_o |-> $past(mem_wr_i.wr) && cmd_addr_o == $past(mem_wr_i.addr)
      && cmd_data_o == $past(mem_wr_i.wdata);
  endproperty
  property p_key_nocmd; s_key_win |-> !cmd_start_o; endproperty
  property p_deny; s_deny |-> !mem_acc_grant_o; endproperty
  property p_grant_ok; mem_acc_req_i && !unsecure_src_i |=> mem_acc_grant_o; endproperty
  property p_blank; blank_ok_i |-> ##2 !secure_o; endproperty
  property p_stay_open; !secure_o |=> !secure_o; endproperty
  property p_no_unlock;
    $past(rst_b_i, 2) && secure_o && !backdoor_key_enable_o && !$past(blank_ok_i)
      |=> secure_o;
  endproperty
  property p_viol_hold;
    protection_violation_flag_o && !$past(clr_w) |=> protection_violation_flag_o;
  endproperty

  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not idle");
  a_cmd_src: assert property (p_cmd_src)
    else $error("command without matching write");
  a_key_nocmd: assert property (p_key_nocmd)
    else $error("key window write started a command");
  a_deny: assert property (p_deny)
    else $error("secured part granted access");
  a_grant_ok: assert property (p_grant_ok)
    else $error("secure source refused");
  a_blank: assert property (p_blank)
    else $error("blank pass did not unsecure");
  a_stay_open: assert property (p_stay_open)
    else $error("security returned before reset");
  a_no_unlock: assert property (p_no_unlock)
    else $error("unlocked with key disabled");
  a_viol_hold: assert property (p_viol_hold)
    else $error("violation flag lost");
endmodule // fspc_ctrl_sva

bind fspc_ctrl fspc_ctrl_sva u_sva (.clk_i, .rst_b_i, .reg_req_i, .rd_data_o, .mem_wr_i,
  .mem_acc_req_i, .unsecure_src_i, .blank_ok_i, .mem_acc_grant_o, .cmd_start_o,
  .cmd_addr_o, .cmd_data_o, .secure_o, .backdoor_key_enable_o, .key_access_enable_o,
  .protection_violation_flag_o);

/* bench/fspc_bus_model.sv */
// cpu bus and debug port model issuing register and flash writes
`timescale 1ns/1ns
module fspc_bus_model
  import fspc_pkg::*;
(
  input  wire logic       clk_i,     // bus clock
  input  wire logic [7:0] rd_data_i, // read data
  output fspc_reg_req_s   reg_req_o, // register request
  output fspc_mem_wr_s    mem_wr_o   // flash write
);
  // idle bus at time zero
  initial
  begin
    reg_req_o = '0;
    mem_wr_o = '0;
  end

  // one register cycle; released data lines toggle so stale values never match
  task automatic reg_acc(input logic w, d, input logic [2:0] i, input logic [7:0] v,
                         output logic [7:0] q);
    @(negedge clk_i);
    reg_req_o = {w, !w, d, i, v};
    @(negedge clk_i);
    q = rd_data_i;
    reg_req_o = {3'h0, i, ~v};
  endtask

  // one flash write, never on adjacent cycles
  task automatic mem_put(input logic d, input logic [15:0] a, input logic [7:0] v);
    @(negedge clk_i);
    mem_wr_o = {1'b1, d, a, v};
    @(negedge clk_i);
    mem_wr_o = {1'b0, d, ~a, ~v};
  endtask

  // open key window, eight bytes ascending (sw swaps pairs), close
  task automatic key_entry(input logic d, input logic [63:0] k, input logic sw);
    logic [7:0] q;
    logic [2:0] m;
    reg_acc(1'b1, 1'b0, FSPC_IDX_CFG, 8'h20, q);
    for (int n = 0; n < FSPC_KEY_BYTES; n++)
    begin
      m = n[2:0] ^ {2'b00, sw};
      mem_put(d, FSPC_KEY_BASE + {13'h0000, m}, k[8*m +: 8]);
    end
    reg_acc(1'b1, 1'b0, FSPC_IDX_CFG, 8'h00, q);
  endtask
endmodule // fspc_bus_model

/* bench/tb.sv */
// self-checking bench for the flash security and protection control block
`timescale 1ns/1ns
module tb
  import fspc_pkg::*;
;
  localparam logic [63:0] KEY = 64'h5EC2_7A19_C3D4_E5F6;
  logic          clk_i = 1'b0;
  logic          rst_b_i = 1'b0;
  logic [7:0]    nv_options_copy_i = 8'h00;
  logic [7:0]    nv_protection_copy_i = 8'h01;
  logic [63:0]   stored_backdoor_key_i = KEY;
  fspc_reg_req_s reg_req_i;
  fspc_mem_wr_s  mem_wr_i;
  logic          mem_acc_req_i = 1'b0;
  logic          unsecure_src_i = 1'b0;
  logic          blank_ok_i = 1'b0;
  logic [7:0]    rd_data_o, cmd_data_o, rq;
  logic [15:0]   cmd_addr_o;
  logic          mem_acc_grant_o, cmd_start_o, secure_o, vector_redirect_en_o;
  logic          backdoor_key_enable_o, key_access_enable_o, protection_violation_flag_o;
  int            n_fail = 0;
  int            check_count = 0;
  int            n_cmd = 0;
  int            cyc = 0;

  fspc_ctrl DUT (.clk_i, .rst_b_i, .nv_options_copy_i, .nv_protection_copy_i,
    .stored_backdoor_key_i, .reg_req_i, .rd_data_o, .mem_wr_i, .mem_acc_req_i,
    .unsecure_src_i, .blank_ok_i, .mem_acc_grant_o, .cmd_start_o, .cmd_addr_o,
    .cmd_data_o, .secure_o, .vector_redirect_en_o, .backdoor_key_enable_o,
    .key_access_enable_o, .protection_violation_flag_o);
  fspc_bus_model bus (.clk_i, .rd_data_i(rd_data_o), .reg_req_o(reg_req_i),
    .mem_wr_o(mem_wr_i));

  // 25 MHz clock
  always #20 clk_i = ~clk_i;

  // command pulse count and hang guard, far above the run length
  always @(posedge clk_i)
  begin
    cyc = cyc + 1;
    if (cmd_start_o === 1'b1)
      n_cmd = n_cmd + 1;
    if (cyc == 6000)
    begin
      n_fail = n_fail + 1;
      close_out();
    end
  end

  task automatic close_out();
    if (n_fail == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // reset with fresh nonvolatile bytes, six cycles low
  task automatic rst_to(input logic [7:0] o, p);
    nv_options_copy_i = o;
    nv_protection_copy_i = p;
    rst_b_i = 1'b0;
    repeat (6) @(negedge clk_i);
    rst_b_i = 1'b1;
    repeat (3) @(negedge clk_i);
  endtask

  task automatic wr(input logic d, input logic [2:0] i, input logic [7:0] v);
    bus.reg_acc(1'b1, d, i, v, rq);
  endtask

  task automatic rd(input logic [2:0] i);
    bus.reg_acc(1'b0, 1'b0, i, 8'h00, rq);
  endtask

  // one access request; grant shows the cycle after
  task automatic acc(input logic src, exp);
    @(negedge clk_i);
    mem_acc_req_i = 1'b1;
    unsecure_src_i = src;
    @(negedge clk_i);
    mem_acc_req_i = 1'b0;
    chk(mem_acc_grant_o, exp);
  endtask

  task automatic put_chk(input logic [15:0] a, input logic e);
    logic [7:0] v;
    v = ~a[7:0];
    bus.mem_put(1'b0, a, v);
    chk(cmd_start_o, e);
    if (e)
    begin
      chk(cmd_addr_o, a);
      chk(cmd_data_o, v);
    end
  endtask

  // every security code, redirect and key enable, with reserved bits set
  task automatic t_opts();
    logic [7:0] o;
    for (int i = 0; i < 4; i++)
    begin
      o = 8'h3C | {i[1], i[0], 4'h0, i[1:0]};
      rst_to(o, 8'h01);
      rd(FSPC_IDX_OPT);
      chk(rq, o & 8'hC3);
      chk(secure_o, i != 2);
      chk(vector_redirect_en_o, !i[0]);
      chk(backdoor_key_enable_o, i[1]);
      wr(1'b1, FSPC_IDX_OPT, ~o);
      rd(FSPC_IDX_OPT);
      chk(rq, o & 8'hC3);
    end
    rd(FSPC_IDX_CFG);
    chk(rq, 8'h00);
    wr(1'b0, FSPC_IDX_CFG, 8'hFF);
    rd(FSPC_IDX_CFG);
    chk(rq, 8'h20);
    chk(key_access_enable_o, 1'b1);
    wr(1'b0, FSPC_IDX_CFG, 8'h00);
    rd(3'h7);
    chk(rq, 8'h00);
    rd(FSPC_IDX_PROT);
    chk(rq, 8'h01);
  endtask

  // debug bytes, wrong order, then a good entry
  task automatic t_key();
    int n;
    rst_to(8'h80, 8'h01);
    acc(1'b1, 1'b0);
    acc(1'b0, 1'b1);
    n = n_cmd;
    bus.key_entry(1'b1, KEY, 1'b0);
    repeat (4) @(negedge clk_i);
    chk(secure_o, 1'b1);
    bus.key_entry(1'b0, KEY, 1'b1);
    repeat (4) @(negedge clk_i);
    chk(secure_o, 1'b1);
    bus.key_entry(1'b0, KEY ^ 64'h1, 1'b0);
    repeat (4) @(negedge clk_i);
    chk(secure_o, 1'b1);
    bus.key_entry(1'b0, KEY, 1'b0);
    repeat (4) @(negedge clk_i);
    chk(secure_o, 1'b0);
    chk(16'(n_cmd), 16'(n));
    acc(1'b1, 1'b1);
  endtask

  task automatic t_nokey();
    rst_to(8'h00, 8'h01);
    bus.key_entry(1'b0, KEY, 1'b0);
    repeat (4) @(negedge clk_i);
    chk(secure_o, 1'b1);
  endtask

  task automatic t_blank();
    rst_to(8'h00, 8'h01);
    @(negedge clk_i);
    blank_ok_i = 1'b1;
    @(negedge clk_i);
    blank_ok_i = 1'b0;
    repeat (2) @(negedge clk_i);
    chk(secure_o, 1'b0);
  endtask

  // key window in command mode; protection disabled covers everything
  task automatic t_cmd();
    rst_to(8'h02, 8'h01);
    put_chk(16'hFFB3, 1'b1);
    put_chk(16'hFFFE, 1'b1);
  endtask

  // grow-only region, debug-only writes, boundary and violation flag
  task automatic t_prot();
    logic [19:0] t [6] = '{20'h0_20_81, 20'h1_F1_F1, 20'h1_C0_C0,
                           20'h1_E0_C0, 20'h1_C1_C0, 20'h1_A0_A0};
    rst_to(8'h02, 8'h81);
    for (int i = 0; i < 6; i++)
    begin
      wr(t[i][16], FSPC_IDX_PROT, t[i][15:8]);
      rd(FSPC_IDX_PROT);
      chk(rq, t[i][7:0]);
    end
    put_chk(16'hA1FF, 1'b1);
    put_chk(16'hA200, 1'b0);
    repeat (2) @(negedge clk_i);
    chk(protection_violation_flag_o, 1'b1);
    rd(FSPC_IDX_STAT);
    chk(rq, 8'h20);
    wr(1'b0, FSPC_IDX_STAT, 8'h20);
    repeat (2) @(negedge clk_i);
    chk(protection_violation_flag_o, 1'b0);
  endtask

  // main sequence
  initial
  begin
    t_opts();
    t_key();
    t_nokey();
    t_blank();
    t_cmd();
    t_prot();
    close_out();
  end
endmodule // tb
